// *** rtl/spm_ctrl.sv ***
// Serial port mode and direction control with debug rerouting.
`default_nettype none
module spm_ctrl (
   input wire logic ref_clk,          // 20 MHz system clock.
   input wire logic rstn,             // Asynchronous reset, active low.
   input wire logic mode_sel_a,       // Expander mode line A level.
   input wire logic mode_sel_b,       // Expander mode line B level.
   input wire logic mode_sel_oe_n,    // Low when both select lines drive.
   input wire logic dbg_en,           // Serial debugging requested.
   input wire logic uart_tx,          // Main UART transmit data.
   input wire logic uart_rts,         // Main UART RTS or direction.
   input wire logic uart_dtr,         // Main UART DTR.
   input wire logic dbg_tx,           // Debug UART transmit data.
   input wire logic pin_rx,           // Connector RX or RX pair level.
   input wire logic pin_dsr,          // Connector DSR or debug RX level.
   input wire logic pin_cts,          // Connector CTS or CTS pair level.
   output logic pin_tx,               // Connector TX level.
   output logic pin_dtr,              // Connector DTR or debug TX.
   output logic pin_rts,              // Connector RTS level.
   output logic pin_tx_oe_n,          // Transmit driver enable, low on.
   output logic rs485_dir_line,       // Direction, high transmits.
   output logic uart_rx,              // Main UART receive data.
   output logic uart_dsr,             // Main UART DSR.
   output logic uart_cts,             // Main UART CTS.
   output logic dbg_rx,               // Debug UART receive data.
   output logic dbg_active,           // Debug rerouting in force.
   output spm_pkg::spm_mode_t mode_now // Mode applied to the port.
);
   spm_pkg::spm_pins_in_t pin_in;
   spm_pkg::spm_mode_t mode_next;
   logic dbg_next;
   logic dir_next;

   // Pins are asynchronous to ref_clk, so filter them first.
   spm_sync #(
      .WIDTH($bits(spm_pkg::spm_pins_in_t))
   ) u_sync (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .d_in({pin_rx, pin_dsr, pin_cts}),
      .q_out(pin_in)
   );

   // Decodes the two select levels into a mode.
   function automatic spm_pkg::spm_mode_t decode_mode(
      input logic a,
      input logic b
   );
      spm_pkg::spm_mode_t m;
      case ({a, b})
         2'h2: m = spm_pkg::SPM_MODE_232;
         2'h3: m = spm_pkg::SPM_MODE_422;
         2'h1: m = spm_pkg::SPM_MODE_485;
         default: m = spm_pkg::SPM_MODE_OFF;
      endcase
      return m;
   endfunction

   // Select levels are trusted only while both lines drive; otherwise
   // the last valid mode is kept, avoiding glitches during setup.
   always_comb begin
      mode_next = mode_now;
      if (!mode_sel_oe_n) begin
         mode_next = decode_mode(mode_sel_a, mode_sel_b);
      end
   end

   // Debug reroute only makes sense with single-ended RS232 pins.
   assign dbg_next = dbg_en && (mode_next == spm_pkg::SPM_MODE_232);

   // Direction follows controller RTS in RS485, else receive.
   assign dir_next = (mode_next == spm_pkg::SPM_MODE_485) ?
                     uart_rts : spm_pkg::SPM_DIR_RST;

   // Mode and debug state register.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         mode_now <= spm_pkg::SPM_MODE_RST;
         dbg_active <= 1'h0;
      end else begin
         mode_now <= mode_next;
         dbg_active <= dbg_next;
      end
   end

   // Direction line, low out of reset so the bus is not driven.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rs485_dir_line <= spm_pkg::SPM_DIR_RST;
      end else begin
         rs485_dir_line <= dir_next;
      end
   end

   // Connector outputs per mode.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pin_tx <= 1'h1;
         pin_dtr <= 1'h0;
         pin_rts <= 1'h0;
         pin_tx_oe_n <= 1'h1;
      end else begin
         pin_tx <= uart_tx;
         pin_dtr <= dbg_next ? dbg_tx : uart_dtr;
         // RTS pin carries controller RTS in 232/422, held low in 485.
         pin_rts <= (mode_next == spm_pkg::SPM_MODE_485) ?
                    1'h0 : uart_rts;
         case (mode_next)
            spm_pkg::SPM_MODE_232: pin_tx_oe_n <= 1'h0;
            spm_pkg::SPM_MODE_422: pin_tx_oe_n <= 1'h0;
            spm_pkg::SPM_MODE_485: pin_tx_oe_n <= ~uart_rts;
            default: pin_tx_oe_n <= 1'h1;
         endcase
      end
   end

   // UART inputs; in RS485 echo of own transmission is blanked.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         uart_rx <= 1'h1;
         uart_dsr <= 1'h0;
         uart_cts <= 1'h0;
         dbg_rx <= 1'h1;
      end else begin
         if (mode_next == spm_pkg::SPM_MODE_485 && uart_rts) begin
            uart_rx <= 1'h1;
         end else begin
            uart_rx <= pin_in.rx;
         end
         uart_dsr <= dbg_next ? 1'h0 : pin_in.dsr;
         dbg_rx <= dbg_next ? pin_in.dsr : 1'h1;
         uart_cts <= (mode_next == spm_pkg::SPM_MODE_485) ?
                     1'h0 : pin_in.cts;
      end
   end

   // Debug reroute never active outside RS232.
   dbg_mode_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      dbg_active |-> mode_now == spm_pkg::SPM_MODE_232)
      else $error("debug reroute outside RS232");

   // Direction follows RTS one cycle later in RS485.
   dir_follow_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (mode_next == spm_pkg::SPM_MODE_485) |=>
      rs485_dir_line == $past(uart_rts))
      else $error("direction does not follow RTS");

   // Direction low whenever not in RS485.
   dir_idle_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (mode_now != spm_pkg::SPM_MODE_485) |-> !rs485_dir_line)
      else $error("direction high outside RS485");

   // Driver enable agrees with direction in RS485.
   hdx_drv_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (mode_now == spm_pkg::SPM_MODE_485) |->
      pin_tx_oe_n == !rs485_dir_line)
      else $error("driver enable disagrees with direction");

   // Mode decode of RS232 select levels.
   mode_232_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (!mode_sel_oe_n && mode_sel_a && !mode_sel_b) |=>
      mode_now == spm_pkg::SPM_MODE_232)
      else $error("RS232 select not applied");

   // Mode held while select lines do not drive.
   mode_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      mode_sel_oe_n |=> $stable(mode_now))
      else $error("mode changed while select undriven");

   // DTR pin carries debug transmit when rerouted.
   dtr_dbg_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      dbg_next |=> pin_dtr == $past(dbg_tx))
      else $error("DTR pin not carrying debug TX");

   // RTS pin follows UART RTS in RS422.
   rts_422_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (mode_next == spm_pkg::SPM_MODE_422) |=>
      pin_rts == $past(uart_rts))
      else $error("RTS pin not following in RS422");
endmodule
`default_nettype wire

// *** rtl/spm_pkg.sv ***
// Package with mode encodings, pin carriers and reset and synchroniser constants.
`default_nettype none
package spm_pkg;
   // Port electrical mode as chosen by the two expander select lines.
   typedef enum logic [1:0] {
      SPM_MODE_OFF = 2'h0,
      SPM_MODE_485 = 2'h1,
      SPM_MODE_422 = 2'h2,
      SPM_MODE_232 = 2'h3
   } spm_mode_t;

   // Mode as applied to the port after reset.
   localparam spm_mode_t SPM_MODE_RST = SPM_MODE_232;
   // Direction line level after reset: receive.
   localparam logic SPM_DIR_RST = 1'h0;
   // Synchroniser depth for pin inputs.
   localparam int SPM_SYNC_DEPTH = 3;

   // Outputs toward the connector, all pins as logic levels.
   typedef struct packed {
      logic tx;      // TX or TX+ level.
      logic dtr;     // DTR, or debug TX when rerouted.
      logic rts;     // RTS or RTS+ level.
      logic tx_oe_n; // Low while the transmit driver is on.
   } spm_pins_out_t;

   // Inputs from the connector after synchronisation.
   typedef struct packed {
      logic rx;
      logic dsr;
      logic cts;
   } spm_pins_in_t;
endpackage
`default_nettype wire

// *** rtl/spm_sync.sv ***
// Three-stage pin synchroniser with agreement of the last two stages.
`default_nettype none
module spm_sync #(
   parameter int WIDTH = 3
) (
   input wire logic ref_clk,            // System clock.
   input wire logic rstn,               // Asynchronous reset, active low.
   input wire logic [WIDTH-1:0] d_in,   // Raw pin levels.
   output logic [WIDTH-1:0] q_out       // Filtered levels.
);
   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;

   // Chain of three stages; only stage two reads stage one.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= d_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // A change counts once stages two and three agree.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         q_out <= '0;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               q_out[i] <= s3_reg[i];
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** verification/serial_port_mode_direction_ctrl_tb.sv ***
// Self-checking bench for the serial port mode and direction control.
`default_nettype none
module serial_port_mode_direction_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk = 0, rstn = 0, a = 0, b = 0, oe_n = 1, dbg_en = 0;
   logic utx = 1, urts = 0, udtr = 0, dtx = 0, tw = 0;
   logic rxv = 1, dsrv = 0, ctsv = 0, p_rx, p_dsr, p_cts;
   logic ptx, pdtr, prts, poe_n, dir, urx, udsr, ucts, drx, dact;
   spm_pkg::spm_mode_t mode_now;
   int failures = 0, cmp_count = 0;
   logic [1:0] em [4] = '{spm_pkg::SPM_MODE_OFF, spm_pkg::SPM_MODE_485,
      spm_pkg::SPM_MODE_232, spm_pkg::SPM_MODE_422};

   always #25 ref_clk = ~ref_clk;

   spm_ctrl DUT (.ref_clk(ref_clk), .rstn(rstn), .mode_sel_a(a),
      .mode_sel_b(b), .mode_sel_oe_n(oe_n), .dbg_en(dbg_en), .uart_tx(utx),
      .uart_rts(urts), .uart_dtr(udtr), .dbg_tx(dtx), .pin_rx(p_rx),
      .pin_dsr(p_dsr), .pin_cts(p_cts), .pin_tx(ptx), .pin_dtr(pdtr),
      .pin_rts(prts), .pin_tx_oe_n(poe_n), .rs485_dir_line(dir),
      .uart_rx(urx), .uart_dsr(udsr), .uart_cts(ucts), .dbg_rx(drx),
      .dbg_active(dact), .mode_now(mode_now));

   spm_far far (.pin_tx(ptx), .pin_tx_oe_n(poe_n), .two_wire(tw),
      .rx_val(rxv), .dsr_val(dsrv), .cts_val(ctsv), .pin_rx(p_rx),
      .pin_dsr(p_dsr), .pin_cts(p_cts));

   // Inputs change a fixed 5 ns after the edge, away from sampling.
   task step(input int n);
      repeat (n) @(posedge ref_clk);
      #5;
   endtask

   task chk(input logic [1:0] got, input logic [1:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task results;
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // The whole run is about fifty cycles; this bound is far past it.
   initial begin
      #100us;
      failures++;
      results();
   end

   initial begin
      step(2);
      chk(dir, 1'h0);
      chk(mode_now, spm_pkg::SPM_MODE_RST);
      rstn = 1;
      b = 1;
      step(2);
      chk(mode_now, 2'h3);
      // Every select combination with the controller asking to send.
      oe_n = 0;
      urts = 1;
      for (int i = 0; i < 4; i++) begin
         // Levels stand in for expander lines the host writes over I2C.
         {a, b} = i[1:0];
         step(1);
         chk(mode_now, em[i]);
         chk(dir, i == 1);
         chk(prts, i != 1);
         chk(poe_n, i == 0);
      end
      // Half duplex on a joined bus: own echo must not reach the UART.
      {a, b} = 2'h1;
      tw = 1;
      utx = 0;
      rxv = 0;
      step(6);
      chk(urx, 1'h1);
      chk(ucts, 1'h0);
      urts = 0;
      step(1);
      chk(dir, 1'h0);
      chk(poe_n, 1'h1);
      step(6);
      chk(urx, 1'h0);
      // RS232 with debug rerouting of DTR and DSR.
      {a, b} = 2'h2;
      tw = 0;
      dbg_en = 1;
      dtx = 1;
      dsrv = 1;
      ctsv = 1;
      step(6);
      chk(pdtr, 1'h1);
      chk(drx, 1'h1);
      chk(udsr, 1'h0);
      chk(dact, 1'h1);
      chk(ptx, 1'h0);
      chk(ucts, 1'h1);
      dsrv = 0;
      step(6);
      chk(drx, 1'h0);
      // RS422 keeps DTR and DSR even with debug requested.
      b = 1;
      dsrv = 1;
      urts = 1;
      step(1);
      chk(dact, 1'h0);
      chk(pdtr, 1'h0);
      step(6);
      chk(udsr, 1'h1);
      chk(drx, 1'h1);
      chk(urx, 1'h0);
      chk(poe_n, 1'h0);
      chk(prts, 1'h1);
      // With DSR low, a wrongful reroute would show on the debug side.
      dsrv = 0;
      step(6);
      chk(drx, 1'h1);
      // Mid-run reset: outputs return to their idle levels at once.
      rstn = 0;
      step(1);
      chk(ptx, 1'h1);
      chk(poe_n, 1'h1);
      chk(dir, 1'h0);
      chk(urx, 1'h1);
      chk(prts, 1'h0);
      chk(dact, 1'h0);
      chk(mode_now, spm_pkg::SPM_MODE_RST);
      rstn = 1;
      step(2);
      chk(mode_now, spm_pkg::SPM_MODE_422);
      chk(prts, 1'h1);
      results();
   end
endmodule
`default_nettype wire

// *** verification/spm_far.sv ***
// Model of the serial equipment on the far side of the connector.
`default_nettype none
module spm_far (
   input wire logic pin_tx,       // Port transmit level.
   input wire logic pin_tx_oe_n,  // Port driver enable, low on.
   input wire logic two_wire,     // TX and RX joined into one bus.
   input wire logic rx_val,       // Level the equipment sends.
   input wire logic dsr_val,      // Level on the DSR line.
   input wire logic cts_val,      // Level on the CTS line.
   output logic pin_rx,           // Toward the port receiver.
   output logic pin_dsr,          // Toward the port DSR input.
   output logic pin_cts           // Toward the port CTS input.
);
   timeunit 1ns;
   timeprecision 100ps;
   // A joined bus echoes the port while its driver is on, so a port that
   // fails to blank its own echo will show it on the receive side.
   assign pin_rx = (two_wire && !pin_tx_oe_n) ? pin_tx : rx_val;
   // Separate pairs in the full-duplex modes.
   assign pin_dsr = dsr_val;
   assign pin_cts = cts_val;
endmodule
`default_nettype wire
